// [logic/ifc_irq_flag_enable_control.sv]
`timescale 1ns/10ps
`default_nettype none

module ifc_irq_flag_enable_control #(
    parameter int NUM_SRC = 32
) (
    // Clock and reset.
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // Register port.
    input  wire ifc_pkg::ifc_bus_req_t       bus_req,
    output logic [31:0]                      bus_rdata,
    // Peripheral request pulses, same clock.
    input  wire logic [NUM_SRC-1:0]          periph_event,
    // External interrupt pins, asynchronous.
    input  wire logic [ifc_pkg::IFC_EXT_N-1:0] ext_irq_pin,
    // Which flag bits the external inputs drive.
    input  wire logic [ifc_pkg::IFC_EXT_N*5-1:0] ext_irq_slot,
    // Group priority of the request being taken, for proximity timer start.
    input  wire logic [2:0]                  taken_group_priority,
    input  wire logic                        taken_valid,
    // Outputs to the processor core.
    output logic [NUM_SRC-1:0]               irq_pending,
    output logic                             irq_any,
    output ifc_pkg::ifc_cfg_t                cfg,
    output logic                             proximity_start
);
    import ifc_pkg::*;

    logic [31:0]          control_q, control_d;
    logic [NUM_SRC-1:0]   flag_q, flag_d;
    logic [NUM_SRC-1:0]   enable_q, enable_d;
    logic [31:0]          rdata_q, rdata_d;
    logic [IFC_EXT_N-1:0] sync1_q, sync2_q, prev_q;
    logic [IFC_EXT_N-1:0] sync1_d, sync2_d, prev_d;
    logic [IFC_EXT_N-1:0] ext_edge;
    logic [NUM_SRC-1:0]   hw_set;

    // The external pins are not related to core_clk, so a pin edge can land
    // anywhere inside a clock period. The first flop may go metastable; only
    // the second flop is allowed to read it, and every decision downstream is
    // made on the second stage and on its delayed copy.
    //
    // The delayed copy resets to zero. Pins that idle low therefore never
    // show a false falling edge after reset. A pin that idles high, with its
    // polarity bit cleared, would see one rising transition in the pipeline,
    // which is ignored because only rising polarity would report it.
    //
    // Latency from a pin edge to its flag is three core_clk edges: two for
    // the synchroniser and one for the flag register itself.

    // Next values of the synchroniser pipeline.
    always_comb begin
        sync1_d = ext_irq_pin;
        sync2_d = sync1_q;
        prev_d  = sync2_q;
    end

    // Two-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // An edge is reported for exactly one cycle, when the synchronised level
    // differs from the level one cycle earlier in the selected direction.
    // Changing a polarity bit while the pin is steady reports nothing, since
    // both samples agree; software can retarget an input without a spurious
    // request.

    // Edge detection per external input, polarity chosen by control bits.
    always_comb begin
        for (int i = 0; i < IFC_EXT_N; i++) begin
            ext_edge[i] = control_q[IFC_EP_LSB + i] ? (sync2_q[i] & ~prev_q[i])
                                                    : (~sync2_q[i] & prev_q[i]);
        end
    end

    // Peripheral pulses already belong to core_clk and need no synchroniser.
    // Each external input is steered to one flag index chosen at the port;
    // two inputs may share an index, and then either edge sets that flag.
    // An index at or above NUM_SRC must not be given.

    // Merge peripheral pulses and external edges into per-source set terms.
    always_comb begin
        hw_set = periph_event;
        for (int i = 0; i < IFC_EXT_N; i++) begin
            if (ext_edge[i]) begin
                hw_set[ext_irq_slot[i*5 +: 5]] = 1'b1;
            end
        end
    end

    // Register map, by word index on the plain port:
    //   index 0: control word, vector mode, threshold code and polarities.
    //   index 1: request flags, one per source, plain read and write.
    //   index 2: source enables, one per source, plain read and write.
    // Any other index ignores writes and reads as zero.
    //
    // Flag writes are plain writes, not write-one-to-clear. Software that
    // clears one flag must write back the others it wants to keep, and a
    // hardware set in the same cycle is ORed over the written value so that
    // no request raised in the write cycle itself is lost to the write.
    //
    // Read data is registered: it stands in the cycle after the read strobe
    // and returns to zero in the following cycle. Reads have no side effects.

    // Next values of the register file and the read data.
    always_comb begin
        control_d = control_q;
        flag_d    = flag_q;
        enable_d  = enable_q;
        rdata_d   = 32'h0000_0000;
        if (bus_req.wr) begin
            if (bus_req.addr == IFC_ADDR_CONTROL) begin
                control_d = bus_req.wdata & IFC_CONTROL_MASK;
            end else if (bus_req.addr == IFC_ADDR_FLAG) begin
                flag_d = bus_req.wdata[NUM_SRC-1:0];
            end else if (bus_req.addr == IFC_ADDR_ENABLE) begin
                enable_d = bus_req.wdata[NUM_SRC-1:0];
            end
        end
        flag_d = flag_d | hw_set;
        if (bus_req.rd) begin
            if (bus_req.addr == IFC_ADDR_CONTROL) begin
                rdata_d = control_q & IFC_CONTROL_MASK;
            end else if (bus_req.addr == IFC_ADDR_FLAG) begin
                rdata_d = 32'(flag_q);
            end else if (bus_req.addr == IFC_ADDR_ENABLE) begin
                rdata_d = 32'(enable_q);
            end
        end
    end

    // Register stage.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_q <= IFC_CONTROL_RST;
            flag_q    <= NUM_SRC'(IFC_FLAG_RST);
            enable_q  <= NUM_SRC'(IFC_ENABLE_RST);
            rdata_q   <= 32'h0000_0000;
        end else begin
            control_q <= control_d;
            flag_q    <= flag_d;
            enable_q  <= enable_d;
            rdata_q   <= rdata_d;
        end
    end

    // Read data comes straight from its register.
    assign bus_rdata = rdata_q;

    // The pending vector is combinational from two registers, so it changes
    // in the cycle after either the flag or the enable is written. A disabled
    // source still records its flag; enabling it later presents the request
    // at once, which is what lets software poll masked sources.

    assign irq_pending = flag_q & enable_q;
    assign irq_any     = |(flag_q & enable_q);

    // Decoded configuration for the vector logic.
    always_comb begin
        cfg.multi_vector             = control_q[IFC_VEC_CFG_POS];
        cfg.proximity_threshold_code = control_q[IFC_PROX_LSB +: IFC_PROX_W];
        cfg.edge_polarity            = control_q[IFC_EP_LSB +: IFC_EXT_N];
    end

    // The proximity timer itself lives in the vector logic; this block only
    // says whether the request being taken is allowed to start it. Code one
    // is the odd case: it accepts group priority one only, not priority zero,
    // while codes two and up accept every priority at or below the code.

    // Proximity timer start qualification by threshold code.
    always_comb begin
        logic [2:0] prox_code;
        prox_code = control_q[IFC_PROX_LSB +: IFC_PROX_W];
        if (prox_code == IFC_PROX_OFF) begin
            proximity_start = 1'b0;
        end else if (prox_code == IFC_PROX_ONLY1) begin
            proximity_start = taken_valid && (taken_group_priority == 3'h1);
        end else begin
            proximity_start = taken_valid && (taken_group_priority <= prox_code);
        end
    end

endmodule : ifc_irq_flag_enable_control
`default_nettype wire

// [inc/ifc_pkg.sv]
package ifc_pkg;

    // Register indices on the plain register port (word addresses).
    localparam logic [3:0] IFC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] IFC_ADDR_FLAG    = 4'h1;
    localparam logic [3:0] IFC_ADDR_ENABLE  = 4'h2;
    localparam int         IFC_ADDR_W       = 4;

    // Control register field positions.
    localparam int IFC_VEC_CFG_POS = 12;
    localparam int IFC_PROX_LSB    = 8;
    localparam int IFC_PROX_W      = 3;
    localparam int IFC_EXT_N       = 5;
    localparam int IFC_EP_LSB      = 0;

    // Implemented control bits; everything else reads as zero.
    localparam logic [31:0] IFC_CONTROL_MASK = 32'h0000_171F;

    // Values after reset.
    localparam logic [31:0] IFC_CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] IFC_FLAG_RST    = 32'h0000_0000;
    localparam logic [31:0] IFC_ENABLE_RST  = 32'h0000_0000;

    // Threshold code values with special meaning.
    localparam logic [2:0] IFC_PROX_OFF   = 3'h0;
    localparam logic [2:0] IFC_PROX_ONLY1 = 3'h1;

    // Register bus request grouped together.
    typedef struct packed {
        logic [IFC_ADDR_W-1:0] addr;
        logic [31:0]           wdata;
        logic                  wr;
        logic                  rd;
    } ifc_bus_req_t;

    // Decoded control fields presented to the vector logic.
    typedef struct packed {
        logic       multi_vector;
        logic [2:0] proximity_threshold_code;
        logic [4:0] edge_polarity;
    } ifc_cfg_t;

endpackage : ifc_pkg

// [tb/ifc_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ifc_core_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       irq_any,
    input  wire logic [2:0] grp,
    output logic            taken_valid,
    output logic [2:0]      taken_group_priority
);
    // The core takes a pending request one cycle after it appears.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) taken_valid <= 1'b0;
        else taken_valid <= irq_any;
    end
    // Priority shows the inverse while nothing is taken, so stale values never match.
    assign taken_group_priority = taken_valid ? grp : ~grp;
endmodule : ifc_core_model
`default_nettype wire

// [tb/ifc_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module ifc_properties import ifc_pkg::*; #(parameter int NUM_SRC = 32) (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire ifc_bus_req_t       bus_req,
    input wire logic [31:0]        bus_rdata,
    input wire logic [NUM_SRC-1:0] irq_pending,
    input wire logic               irq_any,
    input wire ifc_cfg_t           cfg,
    input wire logic [2:0]         taken_group_priority,
    input wire logic               taken_valid,
    input wire logic               proximity_start
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_ctl_wr; bus_req.wr && bus_req.addr == IFC_ADDR_CONTROL; endsequence
    sequence s_ctl_rd; bus_req.rd && bus_req.addr == IFC_ADDR_CONTROL; endsequence
    a_ctl_write:
    assert property (s_ctl_wr |=> cfg == {$past(bus_req.wdata[12]), $past(bus_req.wdata[10:8]),
        $past(bus_req.wdata[4:0])}) else $error("control fields not taken");
    a_ctl_mask:
    assert property (s_ctl_rd |=> (bus_rdata & ~IFC_CONTROL_MASK) == 32'h0) else $error("bad bits");
    a_rd_idle:
    assert property (!bus_req.rd |=> bus_rdata == 32'h0) else $error("read data outside slot");
    a_any_or:
    assert property (irq_any == (|irq_pending)) else $error("irq_any wrong");
    a_flag_sticky:
    assert property (!$past(bus_req.wr) |-> ($past(irq_pending) & ~irq_pending) == '0)
        else $error("request dropped without a write");
    a_prox_off:
    assert property (cfg.proximity_threshold_code == 3'h0 |-> !proximity_start) else $error("off");
    a_prox_one:
    assert property (cfg.proximity_threshold_code == 3'h1 |-> proximity_start ==
        (taken_valid && taken_group_priority == 3'h1)) else $error("code one wrong");
    a_prox_low:
    assert property (cfg.proximity_threshold_code > 3'h1 && taken_group_priority != 3'h0 |->
        proximity_start == (taken_valid && taken_group_priority <= cfg.proximity_threshold_code))
        else $error("threshold wrong");
endmodule : ifc_properties
bind ifc_irq_flag_enable_control ifc_properties #(.NUM_SRC(NUM_SRC)) u_props (.core_clk, .rst,
    .bus_req, .bus_rdata, .irq_pending, .irq_any, .cfg, .taken_group_priority, .taken_valid,
    .proximity_start);
`default_nettype wire

// [tb/ifc_irq_flag_enable_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ifc_irq_flag_enable_control_tb_top;
    import ifc_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, irq_any, taken_valid, proximity_start;
    ifc_bus_req_t bus_req = '0;
    logic [31:0] bus_rdata, irq_pending, periph_event = '0;
    logic [4:0] ext_irq_pin = '0;
    logic [2:0] grp = 3'h1, tgp;
    ifc_cfg_t cfg;
    int err_total = 0, n_tests = 0;
    always #25 core_clk = ~core_clk;
    ifc_irq_flag_enable_control #(.NUM_SRC(32)) dut (.core_clk(core_clk), .rst(rst),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .periph_event(periph_event),
        .ext_irq_pin(ext_irq_pin), .ext_irq_slot({5'hE, 5'hD, 5'hC, 5'hB, 5'hA}),
        .taken_group_priority(tgp), .taken_valid(taken_valid), .irq_pending(irq_pending),
        .irq_any(irq_any), .cfg(cfg), .proximity_start(proximity_start));
    ifc_core_model core (.core_clk(core_clk), .rst(rst), .irq_any(irq_any), .grp(grp),
        .taken_valid(taken_valid), .taken_group_priority(tgp));
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [31:0] ev = '0);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        periph_event <= ev;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        periph_event <= '0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 chk("bus_rdata", exp, bus_rdata);
    endtask : rd
    task automatic t_control;
        wr(IFC_ADDR_CONTROL, 32'hFFFF_FFFF);
        rd(IFC_ADDR_CONTROL, IFC_CONTROL_MASK);
        chk("cfg", 32'h1FF, 32'(cfg));
        wr(IFC_ADDR_CONTROL, 32'h0000_0A15);
        chk("cfg", 32'h055, 32'(cfg));
    endtask : t_control
    task automatic t_flags;
        wr(IFC_ADDR_FLAG, 32'h0000_00F0);
        rd(IFC_ADDR_FLAG, 32'h0000_00F0);
        chk("pending", 32'h0, irq_pending);
        wr(IFC_ADDR_ENABLE, 32'h0000_0030);
        chk("pending", 32'h30, irq_pending);
        wr(4'hF, 32'h0, 32'h8);
        rd(IFC_ADDR_FLAG, 32'h0000_00F8);
        wr(IFC_ADDR_FLAG, 32'h0, 32'h2);
        rd(IFC_ADDR_FLAG, 32'h0000_0002);
    endtask : t_flags
    task automatic t_prox;
        wr(IFC_ADDR_FLAG, 32'h20);
        for (int c = 0; c < 8; c++) begin
            wr(IFC_ADDR_CONTROL, 32'(c) << 8);
            for (int p = 1; p < 8; p++) begin
                grp <= 3'(p);
                @(posedge core_clk);
                #1 chk("prox", 32'((c == 1) ? p == 1 : c > 1 && p <= c), 32'(proximity_start));
            end
        end
    endtask : t_prox
    task automatic t_ext;
        wr(IFC_ADDR_CONTROL, 32'h15);
        wr(IFC_ADDR_FLAG, 32'h0);
        ext_irq_pin <= 5'h1F;
        repeat (5) @(posedge core_clk);
        rd(IFC_ADDR_FLAG, 32'h0000_5400);
        wr(IFC_ADDR_FLAG, 32'h0);
        ext_irq_pin <= 5'h0;
        repeat (5) @(posedge core_clk);
        rd(IFC_ADDR_FLAG, 32'h0000_2800);
    endtask : t_ext
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // Main sequence: reset values, then each scenario in turn.
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(IFC_ADDR_CONTROL, 32'h0);
        rd(IFC_ADDR_FLAG, 32'h0);
        rd(IFC_ADDR_ENABLE, 32'h0);
        rd(4'hF, 32'h0);
        t_control;
        t_flags;
        t_prox;
        t_ext;
        give_verdict;
    end
    // Watchdog cuts a hang short after far more cycles than the tests need.
    initial begin
        #(50 * 2000);
        err_total++;
        give_verdict;
    end
endmodule : ifc_irq_flag_enable_control_tb_top
`default_nettype wire
